// ===== common/mtea_pkg.sv
// package of the mac table entry access block: offsets, fields, codes
// assumes one switch core clock and a word-wide management register port
package mtea_pkg;

    // register byte addresses
    localparam logic [15:0] OFS_LU_CTRL = 16'h0418;
    localparam logic [15:0] OFS_ST_CTRL = 16'h041C;
    localparam logic [15:0] OFS_W1      = 16'h0420;
    localparam logic [15:0] OFS_W2      = 16'h0424;
    localparam logic [15:0] OFS_W3      = 16'h0428;
    localparam logic [15:0] OFS_W4      = 16'h042C;

    localparam logic [31:0] REG_RESET   = 32'h00000000;

    // first entry word fields
    localparam int W1_STATIC   = 31;
    localparam int W1_SRC_DROP = 30;
    localparam int W1_DST_DROP = 29;
    localparam int W1_PRIO_HI  = 28;
    localparam int W1_PRIO_LO  = 26;
    localparam int W1_STG_HI   = 2;
    // second word fields
    localparam int W2_OVERRIDE = 31;
    localparam int W2_USE_FGRP = 30;
    localparam int W2_P5       = 6;
    // third word fields
    localparam int W3_FGRP_HI  = 22;
    localparam int W3_FGRP_LO  = 16;
    localparam int W3_MAC_HI   = 15;

    // writable / readable bit masks per view
    localparam logic [31:0] W1_MASK    = 32'hFC000007;
    localparam logic [31:0] W2_LU_MASK = 32'h8000004F;
    localparam logic [31:0] W2_ST_MASK = 32'hC000004F;
    localparam logic [31:0] W3_MASK    = 32'h007FFFFF;
    localparam logic [31:0] W4_MASK    = 32'hFFFFFFFF;

    // static table control fields
    localparam int SC_IDX_HI = 3;
    localparam int SC_TSEL   = 4;
    localparam int SC_READ   = 5;
    localparam int SC_GO     = 7;
    // lookup table control fields
    localparam int LC_OP_HI  = 1;
    localparam int LC_DIRECT = 2;
    localparam int LC_GO     = 7;
    localparam int LC_VALID  = 8;

    localparam logic [1:0] LU_OP_WRITE  = 2'h1;
    localparam logic [1:0] LU_OP_READ   = 2'h2;
    localparam logic [1:0] LU_OP_SEARCH = 2'h3;

    localparam logic [2:0] AGE_DEFAULT = 3'h7;
    localparam int         N_STATIC    = 16;
    localparam logic [3:0] LAST_SLOT   = 4'hF;

    // an entry counts while it is static or its staleness counter is nonzero
    function automatic logic entry_live(input logic [31:0] w1);
        entry_live = w1[W1_STATIC] | (w1[W1_PRIO_HI:W1_PRIO_LO] != 3'h0);
    endfunction

    // second word read mask of the view last accessed
    function automatic logic [31:0] w2_mask(input logic static_view);
        w2_mask = static_view ? W2_ST_MASK : W2_LU_MASK;
    endfunction

    // forward mask packed to five ports, port 5 on top
    function automatic logic [4:0] port_mask(input logic [31:0] w2);
        port_mask = {w2[W2_P5], w2[3:0]};
    endfunction

endpackage

// ===== rtl/mtea_mem.sv
// sixteen-slot static address table storage, four words per slot
// assumes one writer and one reader per cycle on the core clock
`timescale 1ns/1ns
module mtea_mem (
    input  wire logic         clk,
    input  wire logic         we,
    input  wire logic [3:0]   addr,
    input  wire logic [127:0] wdata,
    output logic      [127:0] rdata
);
    logic [127:0] mem [16];

    // read data registered, so users see it one cycle after the address
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule

// ===== rtl/mtea_top.sv
// entry data registers, static address table and forwarding decision
// assumes the lookup engine and frame logic run on MCLK (no crossing needed)
`timescale 1ns/1ns
module mtea_top
    import mtea_pkg::*;
(
    input  wire logic        MCLK,
    input  wire logic        RESET_N,
    input  wire logic [15:0] REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [31:0] REG_RDATA,
    output logic             REG_RVALID,
    output logic      [31:0] ENTRY_W1,
    output logic      [31:0] ENTRY_W2,
    output logic      [31:0] ENTRY_W3,
    output logic      [31:0] ENTRY_W4,
    output logic             LU_REQ,
    output logic      [1:0]  LU_OP,
    output logic             LU_DIRECT,
    output logic             LU_ABORT,
    input  wire logic        LU_DONE,
    input  wire logic        LU_FOUND,
    input  wire logic [31:0] LU_RD_W1,
    input  wire logic [31:0] LU_RD_W2,
    input  wire logic [31:0] LU_RD_W3,
    input  wire logic [31:0] LU_RD_W4,
    input  wire logic        REFR_LEARN,
    input  wire logic        REFR_AGE,
    input  wire logic [31:0] REFR_W1_IN,
    output logic      [31:0] REFR_W1_OUT,
    output logic             REFR_LIVE,
    input  wire logic        FWD_REQ,
    output logic             FWD_READY,
    input  wire logic [47:0] FWD_DA,
    input  wire logic [6:0]  FWD_FGRP,
    input  wire logic        SA_HIT,
    input  wire logic [31:0] SA_W1,
    input  wire logic        DYN_HIT,
    input  wire logic [31:0] DYN_W1,
    input  wire logic [31:0] DYN_W2,
    output logic             FWD_DONE,
    output logic             FWD_DROP,
    output logic             FWD_STATIC,
    output logic      [4:0]  FWD_MASK,
    output logic      [2:0]  FWD_PRIO,
    output logic      [2:0]  FWD_STG,
    output logic             FWD_OVERRIDE
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_STR, ST_LU, ST_SRD, ST_SCMP, ST_DONE
    } mtea_state_t;

    mtea_state_t  state_q, state_d;
    logic [31:0]  w_q [4];
    logic [31:0]  w_d [4];
    logic [31:0]  stc_q, stc_d, luc_q, luc_d;
    logic         view_q, view_d;         // 1: static table view
    logic [3:0]   idx_q, idx_d;
    logic [47:0]  da_q, da_d;
    logic [6:0]   fgrp_q, fgrp_d;
    logic         sa_drop_q, sa_drop_d;
    logic         sth_q, sth_d;
    logic [31:0]  sw1_q, sw1_d, sw2_q, sw2_d;
    logic [31:0]  dw1_q, dw1_d, dw2_q, dw2_d;
    logic         lu_req_d, lu_abort_d;
    logic [31:0]  rdata_d;
    logic         fdone_d, fdrop_d, fstat_d, fovr_d;
    logic [4:0]   fmask_d;
    logic [2:0]   fprio_d, fstg_d;
    logic         mem_we;
    logic [3:0]   mem_addr;
    logic [127:0] mem_rdata;
    logic [31:0]  m1, m2, m3, m4;
    logic         busy, slot_hit, lu_stat, dyn_live;

    assign {m1, m2, m3, m4} = mem_rdata;
    assign busy      = stc_q[SC_GO] | luc_q[LC_GO];
    assign FWD_READY = (state_q == ST_IDLE) && !busy;
    assign ENTRY_W1  = w_q[0];
    assign ENTRY_W2  = w_q[1];
    assign ENTRY_W3  = w_q[2];
    assign ENTRY_W4  = w_q[3];
    assign LU_OP     = luc_q[LC_OP_HI:0];
    assign LU_DIRECT = luc_q[LC_DIRECT];

    // mac from words three and four
    // valid slot matches on mac, and on filter group when asked
    assign slot_hit = m1[W1_STATIC] && ({m3[W3_MAC_HI:0], m4} == da_q)
                   && (!m2[W2_USE_FGRP] || (m3[W3_FGRP_HI:W3_FGRP_LO] == fgrp_q));
    // a zero-age dynamic result is no hit at all
    assign dyn_live = entry_live(dw1_q);
    assign lu_stat  = dw1_q[W1_STATIC];

    mtea_mem u_mem (
        .clk   (MCLK),
        .we    (mem_we),
        .addr  (mem_addr),
        .wdata ({w_q[0], w_q[1], w_q[2], w_q[3]}),
        .rdata (mem_rdata)
    );

    // register file, indirect access sequencer and static table search
    always_comb begin
        state_d = state_q;  w_d = w_q;  stc_d = stc_q;  luc_d = luc_q;
        view_d = view_q;  idx_d = idx_q;  da_d = da_q;  fgrp_d = fgrp_q;
        sa_drop_d = sa_drop_q;  sth_d = sth_q;  sw1_d = sw1_q;  sw2_d = sw2_q;
        dw1_d = dw1_q;  dw2_d = dw2_q;  lu_req_d = 1'b0;  lu_abort_d = 1'b0;
        fdone_d = 1'b0;  fdrop_d = FWD_DROP;  fstat_d = FWD_STATIC;
        fovr_d = FWD_OVERRIDE;  fmask_d = FWD_MASK;  fprio_d = FWD_PRIO;
        fstg_d = FWD_STG;  mem_we = 1'b0;  mem_addr = stc_q[SC_IDX_HI:0];
        // writes during an operation are dropped, except search stop
        if (REG_WR && !busy) begin
            case (REG_ADDR)
                OFS_W1:      w_d[0] = REG_WDATA & W1_MASK;
                OFS_W2:      w_d[1] = REG_WDATA & W2_ST_MASK;
                OFS_W3:      w_d[2] = REG_WDATA & W3_MASK;
                OFS_W4:      w_d[3] = REG_WDATA & W4_MASK;
                OFS_ST_CTRL: stc_d  = REG_WDATA & 32'h000000BF;
                OFS_LU_CTRL: luc_d  = REG_WDATA & 32'h00000087;
                default: ;
            endcase
        end else if (REG_WR && REG_ADDR == OFS_LU_CTRL && luc_q[LC_GO]
                     && !REG_WDATA[LC_GO] && state_q == ST_LU) begin
            luc_d[LC_GO] = 1'b0;           // host stops a running search
            lu_abort_d   = 1'b1;
            state_d      = ST_IDLE;
        end
        case (state_q)
            ST_IDLE: begin
                if (stc_q[SC_GO]) begin
                    // write stores the four words into the slot
                    if (!stc_q[SC_TSEL] && !stc_q[SC_READ]) begin
                        mem_we = 1'b1;
                        view_d = 1'b1;
                    end
                    // go clears once the slot is stored
                    stc_d[SC_GO] = 1'b0;
                    if (!stc_q[SC_TSEL] && stc_q[SC_READ]) begin
                        stc_d[SC_GO] = 1'b1;       // held until data loaded
                        state_d      = ST_STR;
                    end
                end else if (luc_q[LC_GO]) begin
                    // hand the coded operation to the lookup engine
                    lu_req_d        = 1'b1;
                    luc_d[LC_VALID] = 1'b0;
                    state_d         = ST_LU;
                end else if (FWD_REQ) begin
                    da_d   = FWD_DA;
                    fgrp_d = FWD_FGRP;
                    // live source entry with drop bit kills the frame
                    sa_drop_d = SA_HIT && entry_live(SA_W1) && SA_W1[W1_SRC_DROP];
                    dw1_d = DYN_HIT ? DYN_W1 : REG_RESET;
                    dw2_d = DYN_HIT ? DYN_W2 : REG_RESET;
                    sth_d = 1'b0;
                    idx_d = 4'h0;
                    state_d = ST_SRD;
                end
            end
            ST_STR: begin
                // read leaves the slot in the entry words, go clears
                w_d[0] = m1 & W1_MASK;
                w_d[1] = m2 & W2_ST_MASK;
                w_d[2] = m3 & W3_MASK;
                w_d[3] = m4;
                view_d = 1'b1;
                stc_d[SC_GO] = 1'b0;
                state_d = ST_IDLE;
            end
            ST_LU: begin
                if (LU_DONE) begin
                    view_d = 1'b0;
                    if (luc_q[LC_OP_HI:0] != LU_OP_WRITE) begin
                        // nothing valid found gives all-zero words
                        if (LU_FOUND && entry_live(LU_RD_W1)) begin
                            w_d[0] = LU_RD_W1 & W1_MASK;
                            w_d[1] = LU_RD_W2 & W2_LU_MASK;
                            w_d[2] = LU_RD_W3 & W3_MASK;
                            w_d[3] = LU_RD_W4;
                            luc_d[LC_VALID] = 1'b1;
                        end else begin
                            for (int i = 0; i < 4; i++) begin
                                w_d[i] = REG_RESET;
                            end
                        end
                    end
                    // search keeps go while entries keep coming
                    if (!(luc_q[LC_OP_HI:0] == LU_OP_SEARCH && LU_FOUND)) begin
                        luc_d[LC_GO] = 1'b0;
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_SRD: begin
                mem_addr = idx_q;
                state_d  = ST_SCMP;
            end
            ST_SCMP: begin
                mem_addr = idx_q;
                // every one of the sixteen slots is examined
                if (slot_hit && !sth_q) begin
                    sth_d = 1'b1;
                    sw1_d = m1;
                    sw2_d = m2;
                end
                idx_d   = 4'(idx_q + 4'h1);
                state_d = (idx_q == LAST_SLOT) ? ST_DONE : ST_SRD;
            end
            ST_DONE: begin
                // static hit from either table beats a dynamic one
                fdone_d = 1'b1;
                fstat_d = sth_q || lu_stat;
                // destination drop of the chosen entry
                if (sth_q) begin
                    fdrop_d = sa_drop_q || sw1_q[W1_DST_DROP];
                    fmask_d = port_mask(sw2_q);
                    fovr_d  = sw2_q[W2_OVERRIDE];
                    fprio_d = sw1_q[W1_PRIO_HI:W1_PRIO_LO];
                    fstg_d  = sw1_q[W1_STG_HI:0];
                end else if (dyn_live) begin
                    fdrop_d = sa_drop_q || dw1_q[W1_DST_DROP];
                    fmask_d = port_mask(dw2_q);
                    fovr_d  = dw2_q[W2_OVERRIDE];
                    // priority only meaningful for a static entry
                    fprio_d = lu_stat ? dw1_q[W1_PRIO_HI:W1_PRIO_LO] : 3'h0;
                    // tree group in the low three bits
                    fstg_d  = dw1_q[W1_STG_HI:0];
                end else begin
                    fdrop_d = sa_drop_q;
                    fmask_d = 5'h00;      // no hit: flooding is decided elsewhere
                    fovr_d  = 1'b0;
                    fprio_d = 3'h0;
                    fstg_d  = 3'h0;
                end
                state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
        // words read back through the view of the last operation
        case (REG_ADDR)
            OFS_W1:      rdata_d = w_q[0] & W1_MASK;
            OFS_W2:      rdata_d = w_q[1] & w2_mask(view_q);
            OFS_W3:      rdata_d = w_q[2] & W3_MASK;
            OFS_W4:      rdata_d = w_q[3];
            OFS_ST_CTRL: rdata_d = stc_q;
            OFS_LU_CTRL: rdata_d = luc_q;
            default:     rdata_d = REG_RESET;
        endcase
        if (!REG_RD) begin
            rdata_d = REG_RDATA;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            state_q <= ST_IDLE;
            for (int i = 0; i < 4; i++) begin
                w_q[i] <= REG_RESET;
            end
            stc_q <= REG_RESET;  luc_q <= REG_RESET;  view_q <= 1'b0;
            idx_q <= 4'h0;  da_q <= 48'h000000000000;  fgrp_q <= 7'h00;
            sa_drop_q <= 1'b0;  sth_q <= 1'b0;  sw1_q <= REG_RESET;
            sw2_q <= REG_RESET;  dw1_q <= REG_RESET;  dw2_q <= REG_RESET;
            LU_REQ <= 1'b0;  LU_ABORT <= 1'b0;  REG_RDATA <= REG_RESET;
            REG_RVALID <= 1'b0;  FWD_DONE <= 1'b0;  FWD_DROP <= 1'b0;
            FWD_STATIC <= 1'b0;  FWD_OVERRIDE <= 1'b0;  FWD_MASK <= 5'h00;
            FWD_PRIO <= 3'h0;  FWD_STG <= 3'h0;
        end else begin
            state_q <= state_d;  w_q <= w_d;  stc_q <= stc_d;  luc_q <= luc_d;
            view_q <= view_d;  idx_q <= idx_d;  da_q <= da_d;  fgrp_q <= fgrp_d;
            sa_drop_q <= sa_drop_d;  sth_q <= sth_d;  sw1_q <= sw1_d;
            sw2_q <= sw2_d;  dw1_q <= dw1_d;  dw2_q <= dw2_d;
            LU_REQ <= lu_req_d;  LU_ABORT <= lu_abort_d;  REG_RDATA <= rdata_d;
            REG_RVALID <= REG_RD;  FWD_DONE <= fdone_d;  FWD_DROP <= fdrop_d;
            FWD_STATIC <= fstat_d;  FWD_OVERRIDE <= fovr_d;  FWD_MASK <= fmask_d;
            FWD_PRIO <= fprio_d;  FWD_STG <= fstg_d;
        end
    end

    // staleness counter refresh for the lookup engine's entries
    logic [31:0] refr_d;
    always_comb begin
        refr_d = REFR_W1_OUT;
        if (REFR_LEARN) begin
            // learn or access reloads the default age of a non-static entry
            refr_d = REFR_W1_IN;
            if (!REFR_W1_IN[W1_STATIC]) begin
                refr_d[W1_PRIO_HI:W1_PRIO_LO] = AGE_DEFAULT;
            end
        end else if (REFR_AGE) begin
            // static entries are skipped by aging
            refr_d = REFR_W1_IN;
            if (!REFR_W1_IN[W1_STATIC] && REFR_W1_IN[W1_PRIO_HI:W1_PRIO_LO] != 3'h0) begin
                refr_d[W1_PRIO_HI:W1_PRIO_LO] = 3'(REFR_W1_IN[W1_PRIO_HI:W1_PRIO_LO] - 3'h1);
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            REFR_W1_OUT <= REG_RESET;
        end else begin
            REFR_W1_OUT <= refr_d;
        end
    end
    assign REFR_LIVE = entry_live(REFR_W1_OUT);

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESET_N);

    AST_GO_CLEARS: assert property (
        $rose(stc_q[SC_GO]) |-> ##[1:40] !stc_q[SC_GO])
        else $error("static go did not clear");
    AST_READ_LOADS: assert property (
        state_q == ST_STR |=> ENTRY_W4 == $past(m4) && view_q)
        else $error("static read did not load words");
    AST_LU_ZERO: assert property (
        state_q == ST_LU && LU_DONE && !(LU_FOUND && entry_live(LU_RD_W1))
        && LU_OP == LU_OP_READ
        |=> ENTRY_W1 == 32'h00000000 && ENTRY_W4 == 32'h00000000)
        else $error("empty lookup read left data");
    AST_STATIC_WINS: assert property (
        state_q == ST_DONE && (sth_q || lu_stat) |=> FWD_DONE && FWD_STATIC)
        else $error("static hit lost");
    AST_DST_DROP: assert property (
        state_q == ST_DONE && sth_q && sw1_q[W1_DST_DROP] |=> FWD_DROP)
        else $error("destination drop missed");
    AST_SRC_DROP: assert property (
        state_q == ST_IDLE && FWD_READY && FWD_REQ && SA_HIT && SA_W1[W1_STATIC]
        && SA_W1[W1_SRC_DROP] |-> ##34 FWD_DONE && FWD_DROP)
        else $error("source drop missed");
    AST_AGE_RELOAD: assert property (
        REFR_LEARN && !REFR_W1_IN[W1_STATIC]
        |=> REFR_W1_OUT[W1_PRIO_HI:W1_PRIO_LO] == AGE_DEFAULT && REFR_LIVE)
        else $error("age not reloaded");
    AST_DEAD: assert property (
        REFR_AGE && !REFR_LEARN && !REFR_W1_IN[W1_STATIC]
        && REFR_W1_IN[W1_PRIO_HI:W1_PRIO_LO] == 3'h1 |=> !REFR_LIVE)
        else $error("expired entry still live");
    AST_RSVD: assert property (
        REG_RVALID && $past(REG_ADDR) == OFS_W1 |-> REG_RDATA[25:3] == 23'h000000)
        else $error("reserved bits read nonzero");

    COV_ST_READ:  cover property (state_q == ST_STR);
    COV_LU_SRCH:  cover property (state_q == ST_LU && LU_DONE && LU_OP == LU_OP_SEARCH);
    COV_ST_HIT:   cover property (FWD_DONE && FWD_STATIC);
    COV_ABORT:    cover property (LU_ABORT);
endmodule

// ===== sim/mtea_lu_model.sv
// lookup engine model: answers every request with a dead dynamic entry
// assumes requests arrive as one-cycle pulses on the core clock
`timescale 1ns/1ns
module mtea_lu_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        lu_req,
    output logic             lu_done,
    output logic             lu_found,
    output logic      [31:0] w1,
    output logic      [31:0] w
);
    logic [2:0] dly_q;
    // fixed three-cycle answer time
    always_ff @(posedge clk) begin
        if (!rst_n || lu_req) begin
            dly_q <= rst_n ? 3'h3 : 3'h0;
        end else if (dly_q != 3'h0) begin
            dly_q <= dly_q - 3'h1;
        end
    end
    assign lu_done  = (dly_q == 3'h1);
    assign lu_found = lu_done;
    // dead entry delivered
    // released lines show the inverse so a stale value never matches
    assign w1 = lu_done ? 32'h00000005 : 32'hFFFFFFFA;
    assign w  = lu_done ? 32'h0000000F : 32'hFFFFFFF0;
endmodule

// ===== sim/tb_top.sv
// testbench: host register traffic, forwarding and refresh requests
// assumes mtea_top on MCLK with the lookup engine model beside it
`timescale 1ns/1ns
module tb_top import mtea_pkg::*;;
    logic        MCLK, RESET_N, REG_WR, REG_RD, REG_RVALID, LU_REQ, LU_DIRECT, LU_ABORT;
    logic        LU_DONE, LU_FOUND, REFR_LEARN, REFR_AGE, REFR_LIVE, FWD_REQ, FWD_READY;
    logic        SA_HIT, DYN_HIT, FWD_DONE, FWD_DROP, FWD_STATIC, FWD_OVERRIDE;
    logic [1:0]  LU_OP;
    logic [2:0]  FWD_PRIO, FWD_STG;
    logic [4:0]  FWD_MASK;
    logic [6:0]  FWD_FGRP;
    logic [15:0] REG_ADDR;
    logic [47:0] FWD_DA;
    logic [31:0] REG_WDATA, REG_RDATA, ENTRY_W1, ENTRY_W2, ENTRY_W3, ENTRY_W4, LU_RD_W1;
    logic [31:0] LU_RD_W2, LU_RD_W3, LU_RD_W4, REFR_W1_IN, REFR_W1_OUT, SA_W1, DYN_W1, DYN_W2;
    int          errors, compares;
    logic [31:0] rd;

    mtea_top uut (.*);
    mtea_lu_model lum (.clk(MCLK), .rst_n(RESET_N), .lu_req(LU_REQ), .lu_done(LU_DONE),
        .lu_found(LU_FOUND), .w1(LU_RD_W1), .w(LU_RD_W2));
    assign LU_RD_W3 = LU_RD_W2;
    assign LU_RD_W4 = LU_RD_W2;

    always #2 MCLK = ~MCLK;

    task automatic report_and_stop();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic hang();
        errors++;
        report_and_stop();
    endtask
    task automatic tick();
        @(posedge MCLK);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        REG_WR = 1'b1;
        REG_ADDR = a;
        REG_WDATA = d;
        tick();
        REG_WR = 1'b0;
        tick();
    endtask
    task automatic rd_reg(input logic [15:0] a, output logic [31:0] d);
        REG_RD = 1'b1;
        REG_ADDR = a;
        tick();
        REG_RD = 1'b0;
        if (REG_RVALID !== 1'b1) hang();
        d = REG_RDATA;
        tick();
    endtask
    task automatic chkreg(input logic [15:0] a, input logic [31:0] e);
        rd_reg(a, rd);
        check(rd, e);
    endtask
    // poll go clear
    // go polled under a bound; a stuck go ends the run
    task automatic wait_go(input logic [15:0] a);
        for (int n = 0; n < 20; n++) begin
            rd_reg(a, rd);
            if (rd[7] === 1'b0) return;
        end
        hang();
    endtask
    task automatic fwd(input logic [47:0] da);
        FWD_DA = da;
        FWD_REQ = 1'b1;
        tick();
        FWD_REQ = 1'b0;
        for (int n = 0; n < 40; n++) begin
            if (FWD_DONE === 1'b1) return;
            tick();
        end
        hang();
    endtask
    // output checked two edges on, since it holds between pulses
    task automatic refr(input logic l, g, input logic [31:0] w, e, input logic live);
        REFR_LEARN = l;
        REFR_AGE = g;
        REFR_W1_IN = w;
        tick();
        REFR_LEARN = 1'b0;
        REFR_AGE = 1'b0;
        tick();
        check(REFR_W1_OUT, e);
        check(REFR_LIVE, live);
    endtask

    task automatic t_static();
        for (int k = 0; k < 4; k++) wr(OFS_W1 + 16'(k * 4), 32'h00000000);
        // slots 0 to 14 loaded here and slot 15 below, so no slot holds junk
        for (int k = 0; k < 15; k++) begin
            wr(OFS_ST_CTRL, 32'h00000080 | 32'(k));
            wait_go(OFS_ST_CTRL);
        end
        wr(OFS_W1, 32'hFFFFFFFF);
        wr(OFS_W2, 32'hFFFFFFFF);
        wr(OFS_W3, 32'hFFFFFFFF);
        wr(OFS_W4, 32'h12345678);
        wr(OFS_ST_CTRL, 32'h0000008F);
        wait_go(OFS_ST_CTRL);
        for (int k = 0; k < 4; k++) wr(OFS_W1 + 16'(k * 4), 32'h00000000);
        wr(OFS_ST_CTRL, 32'h000000AF);
        wait_go(OFS_ST_CTRL);
        chkreg(OFS_W1, 32'hFC000007);
        chkreg(OFS_W2, 32'hC000004F);
        chkreg(OFS_W3, 32'h007FFFFF);
        chkreg(OFS_W4, 32'h12345678);
        check(ENTRY_W1, 32'hFC000007);
        check(ENTRY_W3, 32'h007FFFFF);
        // table select 1 is not held here: go clears, words stay
        wr(OFS_ST_CTRL, 32'h00000090);
        wait_go(OFS_ST_CTRL);
        check(ENTRY_W4, 32'h12345678);
    endtask
    task automatic t_fwd();
        fwd(48'hFFFF12345678);
        check(FWD_STATIC, 1'b1);
        check(FWD_MASK, 5'h1F);
        check(FWD_DROP, 1'b1);
        check(FWD_PRIO, 3'h7);
        check(FWD_STG, 3'h7);
        check(FWD_OVERRIDE, 1'b1);
        SA_HIT = 1'b1;
        fwd(48'h000000000001);
        check(FWD_DROP, 1'b1);
        check(FWD_STATIC, 1'b0);
        SA_HIT = 1'b0;
        DYN_W1 = 32'h00000000;
        fwd(48'h000000000001);
        check({FWD_DROP, FWD_MASK}, 6'h00);
        DYN_W1 = 32'h80000000;
        DYN_W2 = 32'h00000040;
        fwd(48'h000000000001);
        check({FWD_STATIC, FWD_MASK}, 6'h30);
    endtask
    task automatic t_lookup();
        wr(OFS_LU_CTRL, 32'h00000082);
        wait_go(OFS_LU_CTRL);
        check(LU_OP, LU_OP_READ);
        chkreg(OFS_W1, 32'h00000000);
        chkreg(OFS_W4, 32'h00000000);
        wr(OFS_W2, 32'hFFFFFFFF);
        chkreg(OFS_W2, 32'h8000004F);
        // lookup write leaves the entry words as the host left them
        wr(OFS_LU_CTRL, 32'h00000081);
        wait_go(OFS_LU_CTRL);
        check(LU_OP, LU_OP_WRITE);
        check(ENTRY_W2, 32'hC000004F);
        check(ENTRY_W1, 32'h00000000);
        // search with direct bit: go stays while entries keep coming
        wr(OFS_LU_CTRL, 32'h00000087);
        repeat (8) tick();
        check({FWD_READY, LU_DIRECT, LU_OP}, 4'h7);
        chkreg(OFS_LU_CTRL, 32'h00000087);
        // search stop: the pulse stands one cycle, so looked at inside the write
        REG_WR = 1'b1;
        REG_ADDR = OFS_LU_CTRL;
        REG_WDATA = 32'h00000003;
        tick();
        REG_WR = 1'b0;
        check(LU_ABORT, 1'b1);
        tick();
        chkreg(OFS_LU_CTRL, 32'h00000007);
    endtask

    initial begin
        {MCLK, RESET_N, REG_WR, REG_RD, REFR_LEARN, REFR_AGE, FWD_REQ, SA_HIT} = 8'h00;
        {REG_ADDR, REG_WDATA, REFR_W1_IN, FWD_DA} = 128'h0;
        {errors, compares} = 64'h0;
        FWD_FGRP = 7'h7F;
        SA_W1 = 32'hC0000000;
        DYN_HIT = 1'b1;
        DYN_W1 = 32'h1C000000;
        DYN_W2 = 32'h00000003;
        repeat (10) tick();
        RESET_N = 1'b1;
        for (int k = 0; k < 4; k++) chkreg(OFS_W1 + 16'(k * 4), REG_RESET);
        t_static();
        t_fwd();
        refr(1'b1, 1'b0, 32'h00000005, 32'h1C000005, 1'b1);
        refr(1'b0, 1'b1, 32'h1C000005, 32'h18000005, 1'b1);
        refr(1'b0, 1'b1, 32'h04000000, 32'h00000000, 1'b0);
        refr(1'b1, 1'b1, 32'h9C000000, 32'h9C000000, 1'b1);
        t_lookup();
        report_and_stop();
    end
endmodule
